// ---- src/bdf_top.sv ----
// Top of the two-direction buffer with pass-through and FIFO selection.
// ----------------------------------------------------------------------
// Contract
// ----------------------------------------------------------------------
// Contract
// - Falling A depth strobe captures A bus bits 0..4 as offset X.
// - Falling B depth strobe captures B bus bits 0..4 as offset Y.
// - Full flag low while word count equals defined depth, else high.
// - Empty flag low when no words stored; flags always driven.
// - Pointer reset clears pointers, empty flag low, full flag high.
// - Pointer reset does not force data outputs to any level.
// - Strobe low during reset: depth becomes 32 minus offset on release.
// - Strobe high during reset: depth becomes full 32 words.
// - First load into empty FIFO raises empty flag, word falls through.
// - Fall-through word stays valid until unloaded; writes may continue.
// - To-B select low passes live A bus, high passes A-direction FIFO.
// - To-A select low passes live B bus, high passes B-direction FIFO.
// - To-A drive enable low releases A bus, high drives it.
// - To-B drive enable low releases B bus, high drives it.
// - Load clock rise writes a word, unload clock rise advances read.
// - Loads ignored while full, unloads ignored while empty.
module bdf_top (
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic [bdf_pkg::DATA_W-1:0]  a_bus_i,
  output logic      [bdf_pkg::DATA_W-1:0]  a_bus_o,
  output logic                             a_bus_oe_n,
  input  wire logic [bdf_pkg::DATA_W-1:0]  b_bus_i,
  output logic      [bdf_pkg::DATA_W-1:0]  b_bus_o,
  output logic                             b_bus_oe_n,
  input  wire logic                        depth_strobe_a_dir,
  input  wire logic                        depth_strobe_b_dir,
  input  wire logic                        pointer_reset_a_dir,
  input  wire logic                        pointer_reset_b_dir,
  input  wire logic                        load_clock_a_dir,
  input  wire logic                        load_clock_b_dir,
  input  wire logic                        unload_clock_a_dir,
  input  wire logic                        unload_clock_b_dir,
  output logic                             full_flag_a_dir,
  output logic                             full_flag_b_dir,
  output logic                             empty_flag_a_dir,
  output logic                             empty_flag_b_dir,
  input  wire logic                        source_select_to_b,
  input  wire logic                        source_select_to_a,
  input  wire logic                        drive_enable_to_b,
  input  wire logic                        drive_enable_to_a
);
  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  bdf_pkg::bdf_pins_t pins_raw;
  bdf_pkg::bdf_pins_t sync1_r;
  bdf_pkg::bdf_pins_t sync2_r;
  bdf_pkg::bdf_pins_t prev_r;

  assign pins_raw.a_bus    = a_bus_i;
  assign pins_raw.b_bus    = b_bus_i;
  assign pins_raw.strobe_a = depth_strobe_a_dir;
  assign pins_raw.strobe_b = depth_strobe_b_dir;
  assign pins_raw.prst_a_n = pointer_reset_a_dir;
  assign pins_raw.prst_b_n = pointer_reset_b_dir;
  assign pins_raw.ld_a     = load_clock_a_dir;
  assign pins_raw.ld_b     = load_clock_b_dir;
  assign pins_raw.ul_a     = unload_clock_a_dir;
  assign pins_raw.ul_b     = unload_clock_b_dir;
  assign pins_raw.sel_to_b = source_select_to_b;
  assign pins_raw.sel_to_a = source_select_to_a;
  assign pins_raw.en_to_b  = drive_enable_to_b;
  assign pins_raw.en_to_a  = drive_enable_to_a;

  // Every pin is asynchronous to clk, so all of them pass two stages.
  // Pin clocks must stay below half of clk to be seen edge by edge.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= bdf_pkg::PINS_RST;
      sync2_r <= bdf_pkg::PINS_RST;
      prev_r  <= bdf_pkg::PINS_RST;
    end else begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // ----------------------------------------------------------------------
  // Direction controls
  // ----------------------------------------------------------------------
  bdf_pkg::bdf_ctl_t ctl_a;
  bdf_pkg::bdf_ctl_t ctl_b;

  assign ctl_a.load   = sync2_r.ld_a & ~prev_r.ld_a;
  assign ctl_a.unload = sync2_r.ul_a & ~prev_r.ul_a;
  assign ctl_a.prst_n = sync2_r.prst_a_n;
  assign ctl_a.strobe = sync2_r.strobe_a;
  assign ctl_b.load   = sync2_r.ld_b & ~prev_r.ld_b;
  assign ctl_b.unload = sync2_r.ul_b & ~prev_r.ul_b;
  assign ctl_b.prst_n = sync2_r.prst_b_n;
  assign ctl_b.strobe = sync2_r.strobe_b;

  // ----------------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------------
  logic [bdf_pkg::DATA_W-1:0] q_a;
  logic [bdf_pkg::DATA_W-1:0] q_b;
  logic                       full_n_a;
  logic                       full_n_b;
  logic                       empty_n_a;
  logic                       empty_n_b;

  bdf_fifo u_fifo_a (
    .clk     (clk),
    .arst_n  (arst_n),
    .ctl     (ctl_a),
    .din     (sync2_r.a_bus),
    .q       (q_a),
    .full_n  (full_n_a),
    .empty_n (empty_n_a)
  );

  bdf_fifo u_fifo_b (
    .clk     (clk),
    .arst_n  (arst_n),
    .ctl     (ctl_b),
    .din     (sync2_r.b_bus),
    .q       (q_b),
    .full_n  (full_n_b),
    .empty_n (empty_n_b)
  );

  // ----------------------------------------------------------------------
  // Bus selection and output registers
  // ----------------------------------------------------------------------
  wire [bdf_pkg::DATA_W-1:0] b_sel = sync2_r.sel_to_b ? q_a
                                                      : sync2_r.a_bus;
  wire [bdf_pkg::DATA_W-1:0] a_sel = sync2_r.sel_to_a ? q_b
                                                      : sync2_r.b_bus;

  logic [bdf_pkg::DATA_W-1:0] a_bus_o_r;
  logic [bdf_pkg::DATA_W-1:0] b_bus_o_r;
  logic                       a_oe_n_r;
  logic                       b_oe_n_r;
  logic                       full_a_r;
  logic                       full_b_r;
  logic                       empty_a_r;
  logic                       empty_b_r;

  // The live path costs three clk cycles; that is the price of sampling
  // asynchronous buses cleanly instead of passing them as raw wires.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      a_bus_o_r <= bdf_pkg::Q_RST;
      b_bus_o_r <= bdf_pkg::Q_RST;
      a_oe_n_r  <= 1'b1;
      b_oe_n_r  <= 1'b1;
      full_a_r  <= 1'b1;
      full_b_r  <= 1'b1;
      empty_a_r <= 1'b0;
      empty_b_r <= 1'b0;
    end else begin
      b_bus_o_r <= b_sel;
      a_bus_o_r <= a_sel;
      a_oe_n_r  <= ~sync2_r.en_to_a;
      b_oe_n_r  <= ~sync2_r.en_to_b;
      full_a_r  <= full_n_a;
      full_b_r  <= full_n_b;
      empty_a_r <= empty_n_a;
      empty_b_r <= empty_n_b;
    end
  end

  assign a_bus_o          = a_bus_o_r;
  assign b_bus_o          = b_bus_o_r;
  assign a_bus_oe_n       = a_oe_n_r;
  assign b_bus_oe_n       = b_oe_n_r;
  assign full_flag_a_dir  = full_a_r;
  assign full_flag_b_dir  = full_b_r;
  assign empty_flag_a_dir = empty_a_r;
  assign empty_flag_b_dir = empty_b_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_pin_settled(logic s);
    s ##1 s ##1 s;
  endsequence

  a_select_to_b: assert property (
    sync2_r.sel_to_b |=> b_bus_o == $past(q_a))
    else $error("B bus source wrong with FIFO select.");
  a_live_to_b: assert property (
    !sync2_r.sel_to_b |=> b_bus_o == $past(sync2_r.a_bus))
    else $error("B bus source wrong with live select.");
  a_select_to_a: assert property (
    sync2_r.sel_to_a |=> a_bus_o == $past(q_b))
    else $error("A bus source wrong with FIFO select.");
  a_drive_to_a: assert property (
    s_pin_settled(drive_enable_to_a) |=> ##2 !a_bus_oe_n)
    else $error("A bus not driven when enabled.");
  a_release_b: assert property (
    s_pin_settled(!drive_enable_to_b) |=> ##2 b_bus_oe_n)
    else $error("B bus driven while released.");
  a_flags_track: assert property (
    1'b1 |=> empty_flag_a_dir == $past(empty_n_a)
             && full_flag_b_dir == $past(full_n_b))
    else $error("Status flag does not follow FIFO state.");
  a_live_to_a: assert property (
    !sync2_r.sel_to_a |=> a_bus_o == $past(sync2_r.b_bus))
    else $error("A bus source wrong with live select.");
  // Pin-level checks allow for two synchroniser stages and the output
  // flop; a pin held for under three clk periods is not judged at all.
  a_release_a: assert property (
    s_pin_settled(!drive_enable_to_a) |=> ##2 a_bus_oe_n)
    else $error("A bus driven while released.");
  a_drive_to_b: assert property (
    s_pin_settled(drive_enable_to_b) |=> ##2 !b_bus_oe_n)
    else $error("B bus not driven when enabled.");
endmodule : bdf_top

// ---- src/bdf_fifo.sv ----
// Shared types and constants plus one 32 x 9 fall-through FIFO direction.
// ----------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------
package bdf_pkg;
  localparam int DATA_W    = 9;
  localparam int DEPTH_MAX = 32;
  localparam int OFS_W     = 5;
  localparam logic [DATA_W-1:0] Q_RST = 9'h000;

  typedef struct packed {
    logic load;
    logic unload;
    logic prst_n;
    logic strobe;
  } bdf_ctl_t;

  typedef struct packed {
    logic [DATA_W-1:0] a_bus;
    logic [DATA_W-1:0] b_bus;
    logic              strobe_a;
    logic              strobe_b;
    logic              prst_a_n;
    logic              prst_b_n;
    logic              ld_a;
    logic              ld_b;
    logic              ul_a;
    logic              ul_b;
    logic              sel_to_b;
    logic              sel_to_a;
    logic              en_to_b;
    logic              en_to_a;
  } bdf_pins_t;

  localparam bdf_pins_t PINS_RST = '0;
endpackage : bdf_pkg

// ----------------------------------------------------------------------
// One direction
// ----------------------------------------------------------------------
module bdf_fifo #(
  parameter int W     = bdf_pkg::DATA_W,
  parameter int DEPTH = bdf_pkg::DEPTH_MAX
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire bdf_pkg::bdf_ctl_t ctl,
  input  wire logic [W-1:0]     din,
  output logic      [W-1:0]     q,
  output logic                  full_n,
  output logic                  empty_n
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] depth_r;
  logic [AW-1:0] ofs_r;
  logic          strobe_d_r;
  logic          prst_d_r;
  logic [W-1:0]  q_r;

  wire           in_rst   = ~ctl.prst_n;
  wire           ofs_take = strobe_d_r & ~ctl.strobe;
  wire           rst_rise = ~prst_d_r & ctl.prst_n;
  wire           full     = (cnt_r == depth_r);
  wire           empty    = (cnt_r == '0);
  wire           do_ld    = ctl.load & ~full & ~in_rst;
  wire           do_ul    = ctl.unload & ~empty & ~in_rst;
  wire [AW-1:0]  rd_next  = rd_ptr_r + AW'(1);
  wire [CW-1:0]  depth_nxt = ctl.strobe ? DEPTH_C
                                        : DEPTH_C - CW'(ofs_r);
  wire [CW-1:0]  cnt_nxt  = cnt_r + CW'(do_ld) - CW'(do_ul);

  // Memory has no reset; the pointers and word count define what is valid.
  always_ff @(posedge clk) begin
    if (do_ld) begin
      mem[wr_ptr_r] <= din;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strobe_d_r <= 1'b0;
      prst_d_r   <= 1'b0;
      ofs_r      <= '0;
      depth_r    <= DEPTH_C;
    end else begin
      strobe_d_r <= ctl.strobe;
      prst_d_r   <= ctl.prst_n;
      if (ofs_take) begin
        ofs_r <= din[AW-1:0];
      end
      if (rst_rise) begin
        depth_r <= depth_nxt;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else if (in_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + AW'(do_ld);
      rd_ptr_r <= rd_ptr_r + AW'(do_ul);
      cnt_r    <= cnt_nxt;
    end
  end

  // The head word is held in a register so it falls through on the first
  // load and stays put until unloaded; pointer reset leaves it alone.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q_r <= bdf_pkg::Q_RST;
    end else if (do_ld && (empty || (do_ul && cnt_r == CW'(1)))) begin
      q_r <= din;
    end else if (do_ul && cnt_r > CW'(1)) begin
      q_r <= mem[rd_next];
    end
  end

  assign q       = q_r;
  assign full_n  = ~full;
  assign empty_n = ~empty;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_first_load;
    ctl.prst_n && empty && ctl.load;
  endsequence

  a_offset_capture: assert property (
    ofs_take |=> ofs_r == $past(din[AW-1:0]))
    else $error("Depth offset not captured.");
  a_depth_program: assert property (
    rst_rise && !ctl.strobe |=> depth_r == DEPTH_C - CW'($past(ofs_r)))
    else $error("Programmed depth wrong.");
  a_depth_full: assert property (
    rst_rise && ctl.strobe |=> depth_r == DEPTH_C)
    else $error("Default depth wrong.");
  a_ptr_reset: assert property (
    in_rst |=> !empty_n && full_n && cnt_r == '0)
    else $error("Pointer reset did not clear.");
  a_fall_through: assert property (
    s_first_load |=> empty_n && q == $past(din))
    else $error("First word did not fall through.");
  a_head_hold: assert property (
    ctl.prst_n && !empty && !ctl.unload ##1 !ctl.unload |-> $stable(q))
    else $error("Head word changed without unload.");
  a_full_block: assert property (
    ctl.prst_n && full && ctl.load && !ctl.unload |=>
      $stable(cnt_r) && $stable(wr_ptr_r))
    else $error("Load changed a full FIFO.");
  a_empty_block: assert property (
    ctl.prst_n && empty && ctl.unload && !ctl.load |=>
      cnt_r == '0 && $stable(rd_ptr_r))
    else $error("Unload changed an empty FIFO.");
  a_full_flag: assert property (
    do_ld && !ctl.unload && cnt_r + CW'(1) == depth_r |=> !full_n)
    else $error("Full flag missed the depth.");
endmodule : bdf_fifo

// ---- tb/bdf_bus_agent.sv ----
// Bus agent model that shares one bidirectional data bus with the device.
module bdf_bus_agent (
  input  wire logic                       clk,
  input  wire logic                       drv_en,
  input  wire logic [bdf_pkg::DATA_W-1:0] drv_val,
  input  wire logic                       dev_oe_n,
  input  wire logic [bdf_pkg::DATA_W-1:0] dev_val,
  output logic      [bdf_pkg::DATA_W-1:0] bus_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [bdf_pkg::DATA_W-1:0] last_r;

  // -------------------------------------------------------------------
  // Wire resolution
  // -------------------------------------------------------------------
  // A floating bus has no pull, so it shows the inverse of its last
  // level; a design that samples a released bus sees changing values.
  always_ff @(posedge clk) begin
    last_r <= bus_lvl;
  end
  assign bus_lvl = !dev_oe_n ? dev_val : drv_en ? drv_val : ~last_r;
endmodule : bdf_bus_agent

// ---- tb/test_bidir_dual_fifo_prog_depth.sv ----
// Self-checking bench for the two-direction buffer.
module test_bidir_dual_fifo_prog_depth;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  bdf_pkg::bdf_pins_t p = bdf_pkg::PINS_RST;
  logic ag_a_en = 1'b0;
  logic ag_b_en = 1'b0;
  logic [8:0] a_lvl, b_lvl, a_o, b_o;
  logic a_oe_n, b_oe_n, full_a, full_b, empty_a, empty_b;
  int miscompares = 0;
  int cmp_count = 0;

  always #4 clk = ~clk;

  // -------------------------------------------------------------------
  // Device and bus agents
  // -------------------------------------------------------------------
  bdf_top dut_u (.clk(clk), .arst_n(arst_n), .a_bus_i(a_lvl),
    .a_bus_o(a_o), .a_bus_oe_n(a_oe_n), .b_bus_i(b_lvl), .b_bus_o(b_o),
    .b_bus_oe_n(b_oe_n), .depth_strobe_a_dir(p.strobe_a),
    .depth_strobe_b_dir(p.strobe_b), .pointer_reset_a_dir(p.prst_a_n),
    .pointer_reset_b_dir(p.prst_b_n), .load_clock_a_dir(p.ld_a),
    .load_clock_b_dir(p.ld_b), .unload_clock_a_dir(p.ul_a),
    .unload_clock_b_dir(p.ul_b), .full_flag_a_dir(full_a),
    .full_flag_b_dir(full_b), .empty_flag_a_dir(empty_a),
    .empty_flag_b_dir(empty_b), .source_select_to_b(p.sel_to_b),
    .source_select_to_a(p.sel_to_a), .drive_enable_to_b(p.en_to_b),
    .drive_enable_to_a(p.en_to_a));
  bdf_bus_agent agent_a_u (.clk(clk), .drv_en(ag_a_en), .drv_val(p.a_bus),
    .dev_oe_n(a_oe_n), .dev_val(a_o), .bus_lvl(a_lvl));
  bdf_bus_agent agent_b_u (.clk(clk), .drv_en(ag_b_en), .drv_val(p.b_bus),
    .dev_oe_n(b_oe_n), .dev_val(b_o), .bus_lvl(b_lvl));

  // -------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk_word(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flag

  // Pins are synchronised, so every level is held three cycles and six
  // cycles pass before results are judged (flags settle within five).
  // The agent keeps the bus after a load; scenarios release it.
  task automatic load(input bit b, input logic [8:0] d);
    if (b) begin
      p.b_bus = d;
      ag_b_en = 1'b1;
      tick(1);
      p.ld_b = 1'b1;
      tick(3);
      p.ld_b = 1'b0;
    end else begin
      p.a_bus = d;
      ag_a_en = 1'b1;
      tick(1);
      p.ld_a = 1'b1;
      tick(3);
      p.ld_a = 1'b0;
    end
    tick(3);
  endtask : load

  task automatic unload(input bit b);
    if (b) p.ul_b = 1'b1;
    else p.ul_a = 1'b1;
    tick(3);
    p.ul_a = 1'b0;
    p.ul_b = 1'b0;
    tick(3);
  endtask : unload

  task automatic set_depth(input bit b, input logic [8:0] ofs,
                           input bit prog);
    if (b) begin
      p.b_bus = ofs;
      ag_b_en = prog;
    end else begin
      p.a_bus = ofs;
      ag_a_en = prog;
    end
    tick(3);
    if (b) p.strobe_b = !prog;
    else p.strobe_a = !prog;
    tick(3);
    if (b) p.prst_b_n = 1'b0;
    else p.prst_a_n = 1'b0;
    tick(4);
    p.prst_a_n = 1'b1;
    p.prst_b_n = 1'b1;
    tick(6);
    p.strobe_a = 1'b1;
    p.strobe_b = 1'b1;
    ag_a_en = 1'b0;
    ag_b_en = 1'b0;
    tick(3);
  endtask : set_depth

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic t_reset();
    chk_flag(full_a, 1'b1);
    chk_flag(empty_a, 1'b0);
    chk_flag(full_b, 1'b1);
    chk_flag(empty_b, 1'b0);
    chk_flag(a_oe_n, 1'b1);
    chk_flag(b_oe_n, 1'b1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_fall();
    p.sel_to_b = 1'b1;
    p.en_to_b = 1'b1;
    tick(6);
    chk_flag(b_oe_n, 1'b0);
    load(0, 9'h1A5);
    chk_flag(empty_a, 1'b1);
    chk_word(b_o, 9'h1A5);
    load(0, 9'h05A);
    chk_word(b_o, 9'h1A5);
    unload(0);
    chk_word(b_o, 9'h05A);
    unload(0);
    chk_flag(empty_a, 1'b0);
    unload(0);
    load(0, 9'h123);
    chk_word(b_o, 9'h123);
    unload(0);
    chk_flag(empty_a, 1'b0);
    $display("test fall done");
  endtask : t_fall

  task automatic t_depth_a();
    set_depth(0, 9'h1FE, 1);
    chk_flag(empty_a, 1'b0);
    load(0, 9'h011);
    chk_flag(full_a, 1'b1);
    load(0, 9'h022);
    chk_flag(full_a, 1'b0);
    load(0, 9'h033);
    unload(0);
    chk_flag(full_a, 1'b1);
    chk_word(b_o, 9'h022);
    unload(0);
    chk_flag(empty_a, 1'b0);
    $display("test depth a done");
  endtask : t_depth_a

  // The device must let go of the B bus before the agent writes through it.
  task automatic t_depth_b();
    p.sel_to_a = 1'b1;
    p.en_to_a = 1'b1;
    p.en_to_b = 1'b0;
    tick(6);
    set_depth(1, 9'h1FF, 1);
    load(1, 9'h0C3);
    chk_flag(full_b, 1'b0);
    chk_word(a_o, 9'h0C3);
    chk_flag(a_oe_n, 1'b0);
    set_depth(1, 9'h000, 0);
    chk_flag(full_b, 1'b1);
    chk_flag(empty_b, 1'b0);
    chk_word(a_o, 9'h0C3);
    load(1, 9'h111);
    load(1, 9'h112);
    chk_flag(full_b, 1'b1);
    chk_word(a_o, 9'h111);
    $display("test depth b done");
  endtask : t_depth_b

  // Ten cycles cover the enable turn-around plus the live path latency.
  task automatic t_live();
    p.sel_to_a = 1'b0;
    p.sel_to_b = 1'b0;
    p.en_to_a = 1'b0;
    p.en_to_b = 1'b1;
    p.a_bus = 9'h0F0;
    ag_a_en = 1'b1;
    ag_b_en = 1'b0;
    tick(10);
    chk_word(b_o, 9'h0F0);
    chk_flag(b_oe_n, 1'b0);
    chk_flag(a_oe_n, 1'b1);
    p.en_to_b = 1'b0;
    p.en_to_a = 1'b1;
    ag_a_en = 1'b0;
    p.b_bus = 9'h10F;
    ag_b_en = 1'b1;
    tick(10);
    chk_word(a_o, 9'h10F);
    chk_flag(a_oe_n, 1'b0);
    chk_flag(b_oe_n, 1'b1);
    $display("test live done");
  endtask : t_live

  // -------------------------------------------------------------------
  // Main sequence and watchdog
  // -------------------------------------------------------------------
  initial begin
    p.prst_a_n = 1'b1;
    p.prst_b_n = 1'b1;
    p.strobe_a = 1'b1;
    p.strobe_b = 1'b1;
    tick(6);
    arst_n = 1'b1;
    tick(6);
    t_reset();
    t_fall();
    t_depth_a();
    t_depth_b();
    t_live();
    report_and_stop();
  end

  // The scenarios need under 600 cycles; this span leaves wide margin.
  initial begin
    #40000;
    miscompares++;
    report_and_stop();
  end
endmodule : test_bidir_dual_fifo_prog_depth
